// file: bench/tb_tsw_timeslot_switch.sv
// Self-checking bench: registers, slot mapping and word streams of the timeslot switch
`timescale 1ns/1ps
module tb_tsw_timeslot_switch;
   import tsw_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [31:0] regWrData = 32'h0000_0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic rxWordReady = 1'b0;
   logic txWordValid = 1'b0;
   tsw_word_t txWord = '0;
   // Two slots per half-frame
   logic [4:0] halfSlotsM1 = 5'h01;
   logic [31:0] regRdData, v;
   logic linkClk, linkFs, linkDin, linkDout, linkDoutEn;
   logic rxWordValid, txWordReady, irqA, irqB;
   tsw_word_t rxWord;
   logic [15:0] wo [4] = '{OFF_RX_PTR_B, OFF_TX_PTR_A, OFF_TX_PTR_B, 16'hA818};
   int err_count = 0;
   int comparisons = 0;
   int i;
   always #4 clk = ~clk;
   tsw_timeslot_switch dut (.clk(clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .channelsPerHalfFrameMinusOne(halfSlotsM1), .linkClk(linkClk), .linkFs(linkFs),
      .linkDin(linkDin), .linkDout(linkDout), .linkDoutEn(linkDoutEn),
      .rxWordValid(rxWordValid), .rxWordReady(rxWordReady), .rxWord(rxWord),
      .txWordValid(txWordValid), .txWordReady(txWordReady), .txWord(txWord),
      .halfFrameAIrq(irqA), .halfFrameBIrq(irqB));
   tsw_highway_model hw (.clk(clk), .linkClk(linkClk), .linkFs(linkFs), .linkDin(linkDin),
      .linkDout(linkDout), .linkDoutEn(linkDoutEn));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus tasks start and end in the time step of a rising edge
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      if (regWr === 1'b1) @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] q);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 q = regRdData;
      @(posedge clk);
   endtask
   task automatic tx_push(input logic [31:0] d);
      @(negedge clk) chk("txWordReady", txWordReady, 1'b1);
      @(posedge clk);
      txWordValid <= 1'b1;
      txWord <= '{halfB: 1'b0, data: d};
      @(posedge clk);
      txWordValid <= 1'b0;
   endtask
   task automatic rx_pop(input logic [32:0] exp);
      int k;
      for (k = 0; k < 20; k++) begin
         @(negedge clk);
         if (rxWordValid === 1'b1) break;
      end
      if (k == 20) begin
         err_count++;
         $display("ERROR rxWordValid expected 1 seen 0");
         tally_and_finish();
      end
      chk("rxWord", rxWord, exp);
      @(posedge clk);
      rxWordReady <= 1'b1;
      @(posedge clk);
      rxWordReady <= 1'b0;
   endtask
   task automatic tx_check(input logic [7:0] s1, input logic [7:0] s2);
      chk("slot0En", hw.seenEn[0], 1'b0);
      chk("slot3En", hw.seenEn[3], 1'b0);
      chk("slot1", {hw.seenEn[1], hw.seenByte[1]}, {1'b1, s1});
      chk("slot2", {hw.seenEn[2], hw.seenByte[2]}, {1'b1, s2});
   endtask
   task automatic tally_and_finish;
      $display("COUNTS comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(OFF_TIMESLOT_ENABLE, v);
      chk("enableReset", v, 32'h0000_0000);
      rd(OFF_RX_PTR_A, v);
      chk("rxPtrAReset", v, 32'h0000_0000);
      wr(OFF_TIMESLOT_ENABLE, 32'hFFFF_FFFF);
      rd(OFF_TIMESLOT_ENABLE, v);
      chk("enableMask", v, 32'hFFFF_0000);
      wr(OFF_RX_PTR_A, 32'hFFFF_FFFF);
      rd(OFF_RX_PTR_A, v);
      chk("rxPtrAMask", v, 32'h1F1F_1F1F);
      // Write-only places and one unmapped place read as zero
      foreach (wo[j]) begin
         wr(wo[j], 32'hFFFF_FFFF);
         rd(wo[j], v);
         chk("woRead", v, 32'h0000_0000);
      end
      $display("TEST registers done");
      wr(OFF_TIMESLOT_ENABLE, 32'h813C_0000);
      wr(OFF_RX_PTR_A, 32'h0100_0100);
      wr(OFF_RX_PTR_B, 32'h0100_0001);
      wr(OFF_TX_PTR_A, 32'h0000_0001);
      wr(OFF_TX_PTR_B, 32'h0001_0101);
      hw.slotByte = '{8'hA5, 8'h3C, 8'h96, 8'hC3};
      // First word lands in hold B, second in hold A; the buffer then reports full
      tx_push(32'h5A00_0000);
      tx_push(32'h0000_00E7);
      @(negedge clk) chk("txFull", txWordReady, 1'b0);
      @(posedge clk);
      hw.run_frame(4);
      tx_check(8'h00, 8'h5A);
      // Receiver stalls, so frame two words overflow the buffer
      hw.run_frame(4);
      tx_check(8'hE7, 8'h5A);
      for (i = 0; i < 40 && irqB !== 1'b1; i++) @(negedge clk);
      if (i == 40) begin
         err_count++;
         $display("ERROR irqB expected 1 seen 0");
         tally_and_finish();
      end
      @(posedge clk);
      rx_pop({1'b0, 32'h3CA5_0000});
      rx_pop({1'b1, 32'h0000_96C3});
      @(negedge clk) chk("rxEmpty", rxWordValid, 1'b0);
      @(posedge clk);
      rd(OFF_STATUS, v);
      chk("statusErr", v & 32'h0000_0003, 32'h0000_0003);
      wr(OFF_STATUS, 32'h0000_0003);
      rd(OFF_STATUS, v);
      chk("statusClr", v & 32'h0000_0003, 32'h0000_0000);
      $display("TEST link done");
      tally_and_finish();
   end
endmodule

// file: bench/tsw_highway_model.sv
// Behavioural serial highway: bit clock, frame sync and slot data of the far side
`timescale 1ns/1ps
module tsw_highway_model (
   // System clock for idle line churn
   input wire logic clk,
   // Serial highway
   output logic linkClk,
   output logic linkFs,
   output logic linkDin,
   input wire logic linkDout,
   input wire logic linkDoutEn
);
   logic [7:0] slotByte [4];
   logic [7:0] seenByte [4];
   logic seenEn [4];
   logic inFrame = 1'b0;
   initial begin
      linkClk = 1'b0;
      linkFs = 1'b0;
      linkDin = 1'b0;
   end
   // Idle data keeps toggling so a stale bit cannot pass for a good one
   always @(posedge clk) if (!inFrame) linkDin <= ~linkDin;
   ////////////////////////////////////////
   // Clock stands still between frames; each bit is 64 ns
   task automatic run_frame(input int nSlots);
      inFrame = 1'b1;
      // Sync leads the first rise by several system cycles: its sampled path is one stage longer
      #2 linkFs = 1'b1;
      #30;
      for (int s = 0; s < nSlots; s++) begin
         seenEn[s] = 1'b0;
         for (int b = 7; b >= 0; b--) begin
            #4 linkClk = 1'b1;
            linkDin = slotByte[s][b];
            #32 linkClk = 1'b0;
            #24 seenEn[s] = seenEn[s] | linkDoutEn;
            seenByte[s][b] = linkDout;
            linkFs = 1'b0;
            #4;
         end
      end
      inFrame = 1'b0;
   endtask
endmodule

// file: bench/tsw_timeslot_switch_assertions.sv
// Concurrent checks on the register port and receive stream of the timeslot switch
`timescale 1ns/1ps
module tsw_timeslot_switch_assertions
   import tsw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   // Receive stream
   input wire logic rxWordValid,
   input tsw_pkg::tsw_word_t rxWord,
   input wire logic halfFrameAIrq,
   input wire logic halfFrameBIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   wire logic rdEna = regRd && regAddr == OFF_TIMESLOT_ENABLE;
   wire logic rdPtr = regRd && regAddr == OFF_RX_PTR_A;
   wire logic wrEna = regWr && regAddr == OFF_TIMESLOT_ENABLE;
   wire logic wrPtr = regWr && regAddr == OFF_RX_PTR_A;
   wire logic rdWo = regRd && (regAddr == OFF_RX_PTR_B || regAddr == OFF_TX_PTR_A
      || regAddr == OFF_TX_PTR_B);
   ////////////////////////////////////////
   a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
      else $error("read data not zero outside read answer");
   a_wo_read_zero: assert property (rdWo |=> regRdData == 32'h0000_0000)
      else $error("write-only register read back nonzero");
   a_ena_rsvd_zero: assert property (rdEna |=> regRdData[15:0] == 16'h0000)
      else $error("enable reserved bits nonzero");
   a_ptr_rsvd_zero: assert property (rdPtr |=> (regRdData & ~PTR_MASK) == 32'h0)
      else $error("pointer reserved bits nonzero");
   a_ena_write_read: assert property (wrEna ##1 rdEna |=>
      regRdData == ($past(regWrData, 2) & 32'hFFFF_0000))
      else $error("enable readback differs from write");
   a_ptr_write_read: assert property (wrPtr ##1 rdPtr |=>
      regRdData == ($past(regWrData, 2) & 32'h1F1F_1F1F))
      else $error("pointer readback differs from write");
   a_irqa_word: assert property (halfFrameAIrq && !rxWordValid |=>
      rxWordValid && !rxWord.halfB)
      else $error("word A not offered after its event");
   a_irqb_valid: assert property (halfFrameBIrq |=> rxWordValid)
      else $error("no word offered after event B");
   a_irq_pulse: assert property (halfFrameAIrq |-> !halfFrameBIrq ##1 !halfFrameAIrq)
      else $error("half-frame event not a single pulse");
   c_ena_rw: cover property (wrEna ##1 rdEna);
   c_irq_a: cover property (halfFrameAIrq);
   c_irq_b: cover property (halfFrameBIrq);
endmodule
bind tsw_timeslot_switch tsw_timeslot_switch_assertions u_chk (.clk(clk), .reset(reset),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .rxWordValid(rxWordValid), .rxWord(rxWord),
   .halfFrameAIrq(halfFrameAIrq), .halfFrameBIrq(halfFrameBIrq));

// file: hw/tsw_pair_buf.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module tsw_pair_buf
   import tsw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input tsw_pkg::tsw_word_t inWord,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output tsw_pkg::tsw_word_t outWord
);
   tsw_word_t mem_ff [2];
   logic wrPtr_ff;
   logic rdPtr_ff;
   logic [1:0] count_ff;
   wire doPush = inValid && inReady;
   wire doPop = outValid && outReady;

   assign inReady = (count_ff != 2'h2);
   assign outValid = (count_ff != 2'h0);
   assign outWord = mem_ff[rdPtr_ff];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         if (doPush) wrPtr_ff <= ~wrPtr_ff;
         if (doPop) rdPtr_ff <= ~rdPtr_ff;
         count_ff <= count_ff + {1'b0, doPush} - {1'b0, doPop};
      end
   end

   // Storage needs no reset; only entries counted as valid are ever read
   always_ff @(posedge clk) begin
      if (doPush) mem_ff[wrPtr_ff] <= inWord;
   end
endmodule

// file: hw/tsw_timeslot_switch.sv
// Timeslot switch: pointer registers mapping holding bytes onto TDM timeslots
//
// Summary of operation
// - Enable bits 31:24 gate the eight transmit pointers, one bit each.
// - Enable bits 23:16 gate the eight receive pointers; bits 15:0 reserved.
// - Receive pointer A holds four 5-bit slot numbers for receive word A bytes.
// - Word A serves slots 0 up to the channel count; its pointers are absolute.
// - Receive pointer B holds four 5-bit slots for word B, second half-frame.
// - B pointers are relative; hardware adds channel count plus one back.
// - Transmit pointer A picks the slot in which each transmit A byte goes.
// - Transmit pointer B picks second-half slots for transmit B bytes.
// - After reset all enables and pointer fields are zero.
// - Enable and receive pointer A read back; the other three are write-only.
// - Bits 31:29, 23:21, 15:13, 7:5 of pointer registers are reserved.
// - Holding word bytes 3..0 sit at bits 31:24, 23:16, 15:8, 7:0.
// - Received words alternate A then B, following the half-frame order; transmit words fill hold B then hold A.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module tsw_timeslot_switch
   import tsw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // Frame configuration from the control block
   input wire logic [4:0] channelsPerHalfFrameMinusOne,
   // Serial highway
   input wire logic linkClk,
   input wire logic linkFs,
   input wire logic linkDin,
   output logic linkDout,
   output logic linkDoutEn,
   // Received holding words
   output logic rxWordValid,
   input wire logic rxWordReady,
   output tsw_pkg::tsw_word_t rxWord,
   // Holding words to transmit
   input wire logic txWordValid,
   output logic txWordReady,
   input tsw_pkg::tsw_word_t txWord,
   // Half-frame events
   output logic halfFrameAIrq,
   output logic halfFrameBIrq
);
   import tsw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [4:0] ptrField(input logic [31:0] word, input int k);
      ptrField = word[k * PTR_STRIDE +: PTR_WIDTH];
   endfunction

   function automatic logic [7:0] byteOf(input logic [31:0] word, input int k);
      byteOf = word[k * 8 +: 8];
   endfunction

   // Highest byte whose enabled pointer names the slot; byte 3 wins a tie
   function automatic tsw_match_t slotMatch(input logic [31:0] ptrs, input logic [3:0] ens,
                                            input logic [5:0] slot);
      tsw_match_t m;
      m = '{found: 1'b0, idx: 2'h0};
      for (int k = 3; k >= 0; k--) begin
         if (!m.found && ens[k] && ({1'b0, ptrField(ptrs, k)} == slot)) begin
            m.found = 1'b1;
            m.idx = 2'(k);
         end
      end
      slotMatch = m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register file

   tsw_regs_t regs_ff;
   logic [31:0] rdData_ff;
   logic rxOverrun_ff;
   logic txUnderrun_ff;
   logic [5:0] slot_ff;
   logic inFrame_ff;

   wire selEnable = (regAddr == OFF_TIMESLOT_ENABLE);
   wire selRxA = (regAddr == OFF_RX_PTR_A);
   wire selRxB = (regAddr == OFF_RX_PTR_B);
   wire selTxA = (regAddr == OFF_TX_PTR_A);
   wire selTxB = (regAddr == OFF_TX_PTR_B);
   wire selStatus = (regAddr == OFF_STATUS);

   wire [31:0] statusWord = {15'h0000, inFrame_ff, 2'h0, slot_ff, 6'h00,
                             txUnderrun_ff, rxOverrun_ff};

   // Write-only pointer registers and unmapped addresses read as zero
   wire [31:0] readMux =
      selEnable ? (regs_ff.enable & ENABLE_MASK) :
      selRxA ? (regs_ff.rxA & PTR_MASK) :
      selStatus ? statusWord : 32'h0000_0000;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regs_ff <= '{enable: ENABLE_RESET, rxA: PTR_RESET, rxB: PTR_RESET,
                      txA: PTR_RESET, txB: PTR_RESET};
      end else if (regWr) begin
         if (selEnable) regs_ff.enable <= regWrData & ENABLE_MASK;
         if (selRxA) regs_ff.rxA <= regWrData & PTR_MASK;
         if (selRxB) regs_ff.rxB <= regWrData & PTR_MASK;
         if (selTxA) regs_ff.txA <= regWrData & PTR_MASK;
         if (selTxB) regs_ff.txB <= regWrData & PTR_MASK;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) rdData_ff <= 32'h0000_0000;
      else rdData_ff <= regRd ? readMux : 32'h0000_0000;
   end
   assign regRdData = rdData_ff;

   wire [3:0] txEnA = regs_ff.enable[ENA_TX_LSB +: 4];
   wire [3:0] txEnB = regs_ff.enable[ENA_TX_LSB + ENA_B_OFS +: 4];
   wire [3:0] rxEnA = regs_ff.enable[ENA_RX_LSB +: 4];
   wire [3:0] rxEnB = regs_ff.enable[ENA_RX_LSB + ENA_B_OFS +: 4];

   ////////////////////////////////////////////////////////////////////////////////
   // Link input synchronisers and edge finding

   logic [SYNC_STAGES-1:0] clkSync_ff;
   logic [SYNC_STAGES-1:0] fsSync_ff;
   logic [SYNC_STAGES-1:0] dinSync_ff;
   logic clkLevel_ff;
   logic fsLevel_ff;
   logic dinLevel_ff;
   logic fsAtRise_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clkSync_ff <= '0;
         fsSync_ff <= '0;
         dinSync_ff <= '0;
      end else begin
         clkSync_ff <= {clkSync_ff[1:0], linkClk};
         fsSync_ff <= {fsSync_ff[1:0], linkFs};
         dinSync_ff <= {dinSync_ff[1:0], linkDin};
      end
   end

   // A level counts only once the second and third stages agree
   wire clkAgree = (clkSync_ff[1] == clkSync_ff[2]);
   wire linkRise = clkAgree && clkSync_ff[2] && !clkLevel_ff;
   wire linkFall = clkAgree && !clkSync_ff[2] && clkLevel_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clkLevel_ff <= 1'b0;
         fsLevel_ff <= 1'b0;
         dinLevel_ff <= 1'b0;
      end else begin
         if (clkAgree) clkLevel_ff <= clkSync_ff[2];
         if (fsSync_ff[1] == fsSync_ff[2]) fsLevel_ff <= fsSync_ff[2];
         if (dinSync_ff[1] == dinSync_ff[2]) dinLevel_ff <= dinSync_ff[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame position: a rising frame sync seen at a link rising edge is slot 0, bit 0

   logic [2:0] bit_ff;
   wire frameStart = linkRise && fsLevel_ff && !fsAtRise_ff;
   wire [2:0] nxt_bit = frameStart ? 3'h0 : bit_ff + 3'h1;
   wire [5:0] nxt_slot = frameStart ? 6'h00 :
                         (bit_ff == LAST_BIT && slot_ff != SLOT_MAX) ? slot_ff + 6'h01 :
                         slot_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bit_ff <= 3'h0;
         slot_ff <= 6'h00;
         inFrame_ff <= 1'b0;
         fsAtRise_ff <= 1'b0;
      end else if (linkRise) begin
         fsAtRise_ff <= fsLevel_ff;
         bit_ff <= nxt_bit;
         slot_ff <= nxt_slot;
         inFrame_ff <= inFrame_ff || frameStart;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Half-frame decode: B pointers are offset by channel count plus one

   wire [5:0] chanCount = {1'b0, channelsPerHalfFrameMinusOne};
   wire [5:0] halfBBase = chanCount + 6'h01;
   wire [5:0] halfBLast = 6'((chanCount << 1) + 6'h01);

   function automatic logic inHalfA(input logic [5:0] slot, input logic [5:0] last);
      inHalfA = (slot <= last);
   endfunction

   // Absolute slot range of word A, and relative position within word B
   wire txNowA = inHalfA(nxt_slot, chanCount);
   wire txNowB = !txNowA && (nxt_slot <= halfBLast);
   wire [5:0] txRelB = nxt_slot - halfBBase;
   wire rxNowA = inHalfA(slot_ff, chanCount);
   wire rxNowB = !rxNowA && (slot_ff <= halfBLast);
   wire [5:0] rxRelB = slot_ff - halfBBase;

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit path: holding words A and B, refilled from the buffer

   logic [31:0] txHoldA_ff;
   logic [31:0] txHoldB_ff;
   logic dout_ff;
   logic doutEn_ff;
   tsw_word_t txBufWord;
   logic txBufValid;

   wire fallLastBit = linkFall && inFrame_ff && (bit_ff == LAST_BIT);
   wire endHalfA = fallLastBit && (slot_ff == chanCount);
   wire endHalfB = fallLastBit && (slot_ff == halfBLast);
   wire txPop = endHalfA || endHalfB;

   tsw_pair_buf txBuf (
      .clk(clk),
      .reset(reset),
      .inValid(txWordValid),
      .inReady(txWordReady),
      .inWord(txWord),
      .outValid(txBufValid),
      .outReady(txPop),
      .outWord(txBufWord)
   );

   // Word B is loaded at the end of half A and word A at the end of half B,
   // so each is in place before its first bit goes out
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         txHoldA_ff <= HOLD_RESET;
         txHoldB_ff <= HOLD_RESET;
      end else begin
         if (endHalfA && txBufValid) txHoldB_ff <= txBufWord.data;
         if (endHalfB && txBufValid) txHoldA_ff <= txBufWord.data;
      end
   end

   wire tsw_match_t txMatchA = slotMatch(regs_ff.txA, txEnA, nxt_slot);
   wire tsw_match_t txMatchB = slotMatch(regs_ff.txB, txEnB, txRelB);
   wire txUseA = txNowA && txMatchA.found;
   wire txUseB = txNowB && txMatchB.found;
   wire [7:0] txByte = txUseA ? byteOf(txHoldA_ff, int'(txMatchA.idx)) :
                       byteOf(txHoldB_ff, int'(txMatchB.idx));
   wire [2:0] txBitIdx = LAST_BIT - nxt_bit;

   // Data leaves MSB first on the link rising edge; unmatched slots stay undriven
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dout_ff <= 1'b0;
         doutEn_ff <= 1'b0;
      end else if (linkRise) begin
         dout_ff <= txByte[txBitIdx];
         doutEn_ff <= (inFrame_ff || frameStart) && (txUseA || txUseB);
      end
   end
   assign linkDout = dout_ff;
   assign linkDoutEn = doutEn_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive path: bytes are sampled on the link falling edge

   logic [6:0] rxShift_ff;
   logic [31:0] rxHoldA_ff;
   logic [31:0] rxHoldB_ff;
   logic pushPending_ff;
   logic pushHalfB_ff;
   logic rxBufReady;

   wire rxByteDone = linkFall && inFrame_ff && (bit_ff == LAST_BIT);
   wire [7:0] rxByte = {rxShift_ff, dinLevel_ff};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) rxShift_ff <= 7'h00;
      else if (linkFall) rxShift_ff <= {rxShift_ff[5:0], dinLevel_ff};
   end

   // Every enabled byte whose pointer names the slot captures it; the others keep their value
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rxHoldA_ff <= HOLD_RESET;
         rxHoldB_ff <= HOLD_RESET;
      end else if (rxByteDone) begin
         for (int k = 0; k < 4; k++) begin
            if (rxNowA && rxEnA[k] && ({1'b0, ptrField(regs_ff.rxA, k)} == slot_ff))
               rxHoldA_ff[k * 8 +: 8] <= rxByte;
            if (rxNowB && rxEnB[k] && ({1'b0, ptrField(regs_ff.rxB, k)} == rxRelB))
               rxHoldB_ff[k * 8 +: 8] <= rxByte;
         end
      end
   end

   // Word is handed on the cycle after its last byte lands, A before B
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pushPending_ff <= 1'b0;
         pushHalfB_ff <= 1'b0;
      end else begin
         pushPending_ff <= endHalfA || endHalfB;
         pushHalfB_ff <= endHalfB;
      end
   end

   wire tsw_word_t rxPushWord = '{halfB: pushHalfB_ff,
                                  data: pushHalfB_ff ? rxHoldB_ff : rxHoldA_ff};

   tsw_pair_buf rxBuf (
      .clk(clk),
      .reset(reset),
      .inValid(pushPending_ff),
      .inReady(rxBufReady),
      .inWord(rxPushWord),
      .outValid(rxWordValid),
      .outReady(rxWordReady),
      .outWord(rxWord)
   );

   assign halfFrameAIrq = pushPending_ff && !pushHalfB_ff;
   assign halfFrameBIrq = pushPending_ff && pushHalfB_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status: the link cannot wait, so a full or empty buffer is only reported.
   // A new event in the clearing cycle keeps the flag set.

   wire rxOverSet = pushPending_ff && !rxBufReady;
   wire txUnderSet = txPop && !txBufValid;
   wire statusClr = regWr && selStatus;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rxOverrun_ff <= 1'b0;
         txUnderrun_ff <= 1'b0;
      end else begin
         rxOverrun_ff <= rxOverSet ||
                         (rxOverrun_ff && !(statusClr && regWrData[STAT_RX_OVR_BIT]));
         txUnderrun_ff <= txUnderSet ||
                          (txUnderrun_ff && !(statusClr && regWrData[STAT_TX_UND_BIT]));
      end
   end
endmodule

// file: include/tsw_pkg.sv
// Constants, register map and carrier types of the timeslot switch
package tsw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [15:0] OFF_TIMESLOT_ENABLE = 16'hA804;
   localparam logic [15:0] OFF_RX_PTR_A = 16'hA808;
   localparam logic [15:0] OFF_RX_PTR_B = 16'hA80C;
   localparam logic [15:0] OFF_TX_PTR_A = 16'hA810;
   localparam logic [15:0] OFF_TX_PTR_B = 16'hA814;
   localparam logic [15:0] OFF_STATUS = 16'hA840;

   ////////////////////////////////////////////////////////////////////////////////
   // Field layout
   localparam int ENA_TX_LSB = 24;
   localparam int ENA_RX_LSB = 16;
   localparam int ENA_B_OFS = 4;
   localparam int PTR_WIDTH = 5;
   localparam int PTR_STRIDE = 8;
   localparam logic [31:0] ENABLE_MASK = 32'hFFFF_0000;
   localparam logic [31:0] PTR_MASK = 32'h1F1F_1F1F;
   localparam int STAT_RX_OVR_BIT = 0;
   localparam int STAT_TX_UND_BIT = 1;
   localparam int STAT_SLOT_LSB = 8;
   localparam int STAT_FRAME_BIT = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;
   localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Link timing
   localparam int SYNC_STAGES = 3;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [5:0] SLOT_MAX = 6'h3F;

   ////////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic halfB;
      logic [31:0] data;
   } tsw_word_t;

   typedef struct packed {
      logic [31:0] enable;
      logic [31:0] rxA;
      logic [31:0] rxB;
      logic [31:0] txA;
      logic [31:0] txB;
   } tsw_regs_t;

   typedef struct packed {
      logic found;
      logic [1:0] idx;
   } tsw_match_t;

endpackage
